// ---- rtl/pdmc_ctrl.sv ----
`include "pdmc_defines.svh"
module pdmc_ctrl #(
   parameter int unsigned WAIT_DIV = 1
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sleep_req,
   input wire logic wdt_timer_mode,
   input wire logic ext_irq_pin,
   input wire logic hw_standby_n_pin,
   input wire pdmc_pkg::pdmc_wake_t wake,
   output logic cpu_run,
   output logic osc_run,
   output logic sleep_exc,
   output pdmc_pkg::pdmc_state_t mode,
   output logic [15:0] module_stop_a,
   output logic [15:0] module_stop_b,
   output logic scu_reset,
   output logic periph_reset,
   output pdmc_pkg::pdmc_bus_t bus_ctl,
   output pdmc_pkg::pdmc_clk_en_t clk_en
);

   // Shortening the waits only makes sense for simulation
   if (WAIT_DIV < 1 || WAIT_DIV > 65536) begin : g_chk
      $error("WAIT_DIV out of range");
   end

   logic [15:0] sby_q;
   logic [15:0] msa_q;
   logic [15:0] msb_q;
   logic deep_sel_q;
   logic [5:0] cdiv_q;
   logic [2:0] div_cnt_q;
   logic [19:0] wait_q;
   logic ext_s1_q;
   logic ext_q;
   logic hws_s1_q;
   logic hws_n_q;
   pdmc_pkg::pdmc_state_t state_q;
   logic [31:0] rdata_d;
   logic addr_ok;
   logic wr_acc;
   logic rd_setup;
   logic target;
   logic all_stopped;
   logic acs_ok;
   logic sw_wake;
   logic acs_wake;
   logic any_wake;
   logic per_en;

   // Settle wait per code; reserved codes take the longest wait
   function automatic logic [19:0] wait_len(input logic [4:0] sts);
      logic [19:0] n;
      n = `PDMC_WAIT_512K;
      case (sts)
         5'h05: n = `PDMC_WAIT_64;
         5'h06: n = `PDMC_WAIT_512;
         5'h07: n = `PDMC_WAIT_1K;
         5'h08: n = `PDMC_WAIT_2K;
         5'h09: n = `PDMC_WAIT_4K;
         5'h0A: n = `PDMC_WAIT_16K;
         5'h0B: n = `PDMC_WAIT_32K;
         5'h0C: n = `PDMC_WAIT_64K;
         5'h0D: n = `PDMC_WAIT_128K;
         5'h0E: n = `PDMC_WAIT_256K;
         default: n = `PDMC_WAIT_512K;
      endcase
      n = 20'(n / WAIT_DIV);
      if (n == 20'h0_0000) begin
         n = 20'h0_0001;
      end
      return n;
   endfunction

   // Enable pulse once every 2**sel clocks
   function automatic logic div_en(input logic [2:0] cnt, input logic [1:0] sel);
      logic [2:0] m;
      m = 3'((4'h1 << sel) - 4'h1);
      return (cnt & m) == 3'h0;
   endfunction

   // Two-flop synchronisers for the pins
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ext_s1_q <= 1'b0;
         ext_q <= 1'b0;
         hws_s1_q <= 1'b1;
         hws_n_q <= 1'b1;
      end else begin
         ext_s1_q <= ext_irq_pin;
         ext_q <= ext_s1_q;
         hws_s1_q <= hw_standby_n_pin;
         hws_n_q <= hws_s1_q;
      end
   end

   // Address decode and bus phases
   always_comb begin
      addr_ok = 1'b0;
      if (paddr == `PDMC_OFF_SBY) begin
         addr_ok = 1'b1;
      end else if (paddr == `PDMC_OFF_MSA) begin
         addr_ok = 1'b1;
      end else if (paddr == `PDMC_OFF_MSB) begin
         addr_ok = 1'b1;
      end else if (paddr == `PDMC_OFF_DEEP) begin
         addr_ok = 1'b1;
      end else if (paddr == `PDMC_OFF_STAT) begin
         addr_ok = 1'b1;
      end else if (paddr == `PDMC_OFF_CDIV) begin
         addr_ok = 1'b1;
      end
   end

   assign pready = psel & penable; // Zero wait states
   assign pslverr = psel & penable & ~addr_ok;
   assign wr_acc = psel & penable & pwrite & addr_ok;
   assign rd_setup = psel & ~penable & ~pwrite;

   // Read mux; reserved standby bits come back as zero
   always_comb begin
      rdata_d = 32'h0000_0000;
      if (paddr == `PDMC_OFF_SBY) begin
         rdata_d[15:0] = sby_q & `PDMC_SBY_WMASK;
      end else if (paddr == `PDMC_OFF_MSA) begin
         rdata_d[15:0] = msa_q;
      end else if (paddr == `PDMC_OFF_MSB) begin
         rdata_d[15:0] = msb_q;
      end else if (paddr == `PDMC_OFF_DEEP) begin
         rdata_d[`PDMC_DEEP_SEL] = deep_sel_q;
      end else if (paddr == `PDMC_OFF_STAT) begin
         rdata_d[6:0] = state_q;
      end else if (paddr == `PDMC_OFF_CDIV) begin
         rdata_d[5:0] = cdiv_q;
      end
   end

   // Read data captured in setup, stands through access
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         prdata <= 32'h0000_0000;
      end else if (rd_setup) begin
         prdata <= rdata_d;
      end
   end

   // Control registers change only by software writes
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         sby_q <= `PDMC_SBY_RST;
         msa_q <= `PDMC_MSA_RST;
         msb_q <= `PDMC_MSB_RST;
         deep_sel_q <= 1'b0;
         cdiv_q <= `PDMC_CDIV_RST;
      end else if (wr_acc) begin
         if (paddr == `PDMC_OFF_SBY) begin
            sby_q <= pwdata[15:0] & `PDMC_SBY_WMASK;
         end else if (paddr == `PDMC_OFF_MSA) begin
            msa_q <= pwdata[15:0];
         end else if (paddr == `PDMC_OFF_MSB) begin
            msb_q <= pwdata[15:0];
         end else if (paddr == `PDMC_OFF_DEEP) begin
            deep_sel_q <= pwdata[`PDMC_DEEP_SEL];
         end else if (paddr == `PDMC_OFF_CDIV) begin
            cdiv_q <= pwdata[5:0];
         end
      end
   end

   // Free divider; each domain picks its own ratio
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         div_cnt_q <= 3'h0;
      end else begin
         div_cnt_q <= div_cnt_q + 3'h1;
      end
   end

   assign per_en = div_en(div_cnt_q, cdiv_q[3:2]);

   // Registered enables, independent per domain
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         clk_en <= '0;
      end else begin
         clk_en.sys <= div_en(div_cnt_q, cdiv_q[5:4]);
         clk_en.per <= per_en;
         clk_en.bus <= div_en(div_cnt_q, cdiv_q[1:0]);
      end
   end

   // Transition conditions
   assign target = sby_q[`PDMC_SBY_TARGET] & ~wdt_timer_mode;
   // Timer stop bits left out; those units may run through clock-stop
   assign all_stopped = (&msa_q[14:10]) & (&msa_q[7:0]) & (&msb_q);
   assign acs_ok = msa_q[`PDMC_MSA_ALL_CLOCK_STOP_ENABLE] & all_stopped;
   assign sw_wake = ext_q | wake.usb;
   assign acs_wake = ext_q | wake.tmr | wake.wdt | wake.t32k;
   assign any_wake = acs_wake | wake.usb | wake.other;

   // Sequencer; sleep_req marks the completed sleep instruction
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state_q <= pdmc_pkg::pdmc_run;
         wait_q <= 20'h0_0000;
         sleep_exc <= 1'b0;
      end else begin
         sleep_exc <= 1'b0;
         if (!hws_n_q) begin
            state_q <= pdmc_pkg::pdmc_hwstby;
         end else begin
            case (state_q)
               pdmc_pkg::pdmc_run: begin
                  if (sleep_req) begin
                     if (sby_q[`PDMC_SBY_TRAP]) begin
                        sleep_exc <= 1'b1;
                     end else if (!target) begin
                        state_q <= acs_ok ? pdmc_pkg::pdmc_acstop : pdmc_pkg::pdmc_sleep;
                     end else if (deep_sel_q && !sw_wake) begin
                        state_q <= pdmc_pkg::pdmc_deep;
                     end else begin
                        state_q <= pdmc_pkg::pdmc_swstby;
                     end
                  end
               end
               pdmc_pkg::pdmc_sleep: begin
                  if (any_wake) begin
                     state_q <= pdmc_pkg::pdmc_run;
                  end
               end
               pdmc_pkg::pdmc_acstop: begin
                  if (acs_wake) begin
                     state_q <= pdmc_pkg::pdmc_run;
                  end
               end
               pdmc_pkg::pdmc_swstby, pdmc_pkg::pdmc_deep: begin
                  if (sw_wake) begin
                     state_q <= pdmc_pkg::pdmc_settle;
                     wait_q <= wait_len(sby_q[`PDMC_SBY_STS_HI:`PDMC_SBY_STS_LO]);
                  end
               end
               pdmc_pkg::pdmc_settle: begin
                  if (per_en) begin
                     wait_q <= wait_q - 20'h0_0001;
                     if (wait_q == 20'h0_0001) begin
                        state_q <= pdmc_pkg::pdmc_run;
                     end
                  end
               end
               pdmc_pkg::pdmc_hwstby: begin
                  state_q <= pdmc_pkg::pdmc_settle;
                  wait_q <= wait_len(sby_q[`PDMC_SBY_STS_HI:`PDMC_SBY_STS_LO]);
               end
               default: begin
                  state_q <= pdmc_pkg::pdmc_run;
               end
            endcase
         end
      end
   end

   assign mode = state_q;
   assign cpu_run = state_q == pdmc_pkg::pdmc_run;
   // Oscillator off only in the standby states
   assign osc_run = ~(state_q inside {pdmc_pkg::pdmc_swstby, pdmc_pkg::pdmc_deep,
                                      pdmc_pkg::pdmc_hwstby});

   // Peripheral gating; stops gate clocks, serial and hardware standby resets clear state
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         module_stop_a <= `PDMC_MSA_RST;
         module_stop_b <= `PDMC_MSB_RST;
         scu_reset <= 1'b0;
         periph_reset <= 1'b0;
         bus_ctl <= '0;
      end else begin
         case (state_q)
            pdmc_pkg::pdmc_run, pdmc_pkg::pdmc_sleep: begin
               module_stop_a <= msa_q;
               module_stop_b <= msb_q;
            end
            pdmc_pkg::pdmc_acstop: begin
               module_stop_a <= 16'hFFFF;
               module_stop_a[`PDMC_MSA_TMR_HI] <= msa_q[`PDMC_MSA_TMR_HI];
               module_stop_a[`PDMC_MSA_TMR_LO] <= msa_q[`PDMC_MSA_TMR_LO];
               module_stop_b <= 16'hFFFF;
            end
            default: begin
               module_stop_a <= 16'hFFFF;
               module_stop_b <= 16'hFFFF;
            end
         endcase
         // Serial units lose state in clock-stop and standby; hardware standby resets every peripheral
         scu_reset <= state_q inside {pdmc_pkg::pdmc_acstop, pdmc_pkg::pdmc_swstby,
                                      pdmc_pkg::pdmc_deep};
         periph_reset <= state_q == pdmc_pkg::pdmc_hwstby;
         if (state_q inside {pdmc_pkg::pdmc_swstby, pdmc_pkg::pdmc_deep}) begin
            bus_ctl.hiz <= ~sby_q[`PDMC_SBY_HOLD];
            bus_ctl.hold <= sby_q[`PDMC_SBY_HOLD];
         end else begin
            bus_ctl <= '0;
         end
      end
   end

   // Helper: per-clock states seen in one settle wait
   logic [19:0] seen_q;
   logic [19:0] load_q;
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         seen_q <= 20'h0_0000;
         load_q <= 20'h0_0000;
      end else if (state_q != pdmc_pkg::pdmc_settle) begin
         seen_q <= 20'h0_0000;
         load_q <= wait_len(sby_q[`PDMC_SBY_STS_HI:`PDMC_SBY_STS_LO]);
      end else if (per_en) begin
         seen_q <= seen_q + 20'h0_0001;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   trap_exception_a: assert property (
      cpu_run && sleep_req && sby_q[`PDMC_SBY_TRAP] && hws_n_q |=> sleep_exc && cpu_run)
      else $error("trap did not raise exception");
   sleep_entry_a: assert property (
      cpu_run && sleep_req && !sby_q[`PDMC_SBY_TRAP] && !target && !acs_ok && hws_n_q
      |=> state_q == pdmc_pkg::pdmc_sleep)
      else $error("sleep not entered");
   standby_entry_a: assert property (
      cpu_run && sleep_req && !sby_q[`PDMC_SBY_TRAP] && sby_q[`PDMC_SBY_TARGET]
      && !wdt_timer_mode && !deep_sel_q && hws_n_q |=> state_q == pdmc_pkg::pdmc_swstby)
      else $error("standby not entered");
   deep_entry_a: assert property (
      cpu_run && sleep_req && !sby_q[`PDMC_SBY_TRAP] && target && deep_sel_q
      && !sw_wake && hws_n_q |=> state_q == pdmc_pkg::pdmc_deep)
      else $error("deep standby not entered");
   bus_float_a: assert property (
      state_q == pdmc_pkg::pdmc_swstby && !sby_q[`PDMC_SBY_HOLD] |=> bus_ctl.hiz)
      else $error("bus not floated in standby");
   acstop_hold_a: assert property (
      state_q == pdmc_pkg::pdmc_acstop && !acs_wake && hws_n_q
      |=> state_q == pdmc_pkg::pdmc_acstop)
      else $error("clock-stop left without source");
   settle_len_a: assert property (
      state_q == pdmc_pkg::pdmc_settle ##1 state_q == pdmc_pkg::pdmc_run
      |-> $past(seen_q) + 20'h0_0001 == $past(load_q))
      else $error("settle wait length wrong");
   trap_kept_a: assert property (
      $fell(sby_q[`PDMC_SBY_TRAP]) |-> $past(wr_acc) && $past(paddr) == `PDMC_OFF_SBY)
      else $error("trap bit cleared by hardware");
   target_kept_a: assert property (
      $fell(sby_q[`PDMC_SBY_TARGET]) |-> $past(wr_acc) && $past(paddr) == `PDMC_OFF_SBY)
      else $error("target bit cleared by hardware");
   serial_reset_a: assert property (
      state_q == pdmc_pkg::pdmc_acstop |=> scu_reset)
      else $error("serial units not reset");
   hw_reset_a: assert property (
      state_q == pdmc_pkg::pdmc_hwstby |-> !osc_run ##1 periph_reset)
      else $error("peripherals not reset");
   reserved_zero_a: assert property (
      psel && penable && !pwrite && paddr == `PDMC_OFF_SBY
      |-> prdata[13] == 1'b0 && prdata[6:0] == 7'h00)
      else $error("reserved bits not zero");

   trap_seen_c: cover property (cpu_run && sleep_req ##1 sleep_exc);
   standby_wake_c: cover property (
      state_q == pdmc_pkg::pdmc_swstby ##1 state_q == pdmc_pkg::pdmc_settle);
   acstop_seen_c: cover property (state_q == pdmc_pkg::pdmc_acstop);
   deep_seen_c: cover property (state_q == pdmc_pkg::pdmc_deep);
endmodule

// ---- rtl/pdmc_defines.svh ----
`ifndef PDMC_DEFINES_SVH
`define PDMC_DEFINES_SVH
// Overview of operation
// - Sleep instruction: target 0 sleeps, 1 standbys
// - Standby target survives wake, software clears
// - Watchdog timer mode ignores the standby target
// - Standby bus outputs float or hold
// - Settle code picks wait length, reserved codes
// - Settle wait counts peripheral clock states
// - Trap bit turns sleep into exception
// - Trap bit stays set, software clears
// - Reserved standby bits read zero
// - Module stop bit 1 stops, 0 releases
// - Reset leaves most modules stopped
// - Serial units reset in clock-stop and standby
// - Hardware standby resets every peripheral
// - Clock-stop wakes on external or timer interrupts
// - Standby wakes on external or USB interrupt
// - Timer units follow their stop bits in run, sleep and clock-stop
// - Stopped units retain internal values
// - Clock ratios set independently
// - All stopped plus enable gives clock-stop
// - Deep select sends standby to deep standby
// Register offsets
`define PDMC_OFF_SBY 12'h000
`define PDMC_OFF_MSA 12'h004
`define PDMC_OFF_MSB 12'h008
`define PDMC_OFF_DEEP 12'h00C
`define PDMC_OFF_STAT 12'h010
`define PDMC_OFF_CDIV 12'h014
// Field positions
`define PDMC_SBY_TARGET 15
`define PDMC_SBY_HOLD 14
`define PDMC_SBY_STS_HI 12
`define PDMC_SBY_STS_LO 8
`define PDMC_SBY_TRAP 7
`define PDMC_MSA_ALL_CLOCK_STOP_ENABLE 15
`define PDMC_MSA_TMR_HI 9
`define PDMC_MSA_TMR_LO 8
`define PDMC_DEEP_SEL 7
// Reset values and masks
`define PDMC_SBY_RST 16'h4F00
`define PDMC_SBY_WMASK 16'hDF80
`define PDMC_MSA_RST 16'h0FFF
`define PDMC_MSB_RST 16'hFFFF
`define PDMC_CDIV_RST 6'h00
`define PDMC_SCU_MASK 16'h1700
// Settle wait codes and state counts
`define PDMC_STS_FIRST 5'h05
`define PDMC_STS_LAST 5'h0F
`define PDMC_WAIT_64 20'h0_0040
`define PDMC_WAIT_512 20'h0_0200
`define PDMC_WAIT_1K 20'h0_0400
`define PDMC_WAIT_2K 20'h0_0800
`define PDMC_WAIT_4K 20'h0_1000
`define PDMC_WAIT_16K 20'h0_4000
`define PDMC_WAIT_32K 20'h0_8000
`define PDMC_WAIT_64K 20'h1_0000
`define PDMC_WAIT_128K 20'h2_0000
`define PDMC_WAIT_256K 20'h4_0000
`define PDMC_WAIT_512K 20'h8_0000
`endif

// ---- rtl/pdmc_pkg.sv ----
package pdmc_pkg;
   // One-hot power-down states
   typedef enum logic [6:0] {
      pdmc_run = 7'h01,
      pdmc_sleep = 7'h02,
      pdmc_acstop = 7'h04,
      pdmc_swstby = 7'h08,
      pdmc_deep = 7'h10,
      pdmc_settle = 7'h20,
      pdmc_hwstby = 7'h40
   } pdmc_state_t;
   // Internal wake sources, same clock domain
   typedef struct packed {
      logic tmr;
      logic wdt;
      logic t32k;
      logic usb;
      logic other;
   } pdmc_wake_t;
   // External bus output control during standby
   typedef struct packed {
      logic hiz;
      logic hold;
   } pdmc_bus_t;
   // Clock enable pulses per domain
   typedef struct packed {
      logic sys;
      logic per;
      logic bus;
   } pdmc_clk_en_t;
endpackage

// ---- test/pdmc_cpu_model.sv ----
module pdmc_cpu_model (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic sleep_cmd,
   input wire logic cpu_run,
   input wire logic sleep_exc,
   output logic sleep_req,
   output logic [7:0] exc_count
);
   timeunit 1ns;
   timeprecision 1ps;
   // Sleep retires only while executing; a halted core issues nothing
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         sleep_req <= 1'b0;
      end else begin
         sleep_req <= sleep_cmd & cpu_run & ~sleep_req;
      end
   end
   // Exception entries, counted so the bench sees every trap
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         exc_count <= 8'h00;
      end else if (sleep_exc) begin
         exc_count <= exc_count + 8'h01;
      end
   end
endmodule

// ---- test/tb.sv ----
`include "pdmc_defines.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned WDIV = 16;
   logic clk_sys, reset, psel, penable, pwrite, pready, pslverr, err;
   logic wdt_timer_mode, ext_irq_pin, hw_standby_n_pin, sleep_cmd, sleep_req;
   logic cpu_run, osc_run, sleep_exc, scu_reset, periph_reset;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] module_stop_a, module_stop_b;
   logic [7:0] exc_count;
   pdmc_pkg::pdmc_wake_t wake;
   pdmc_pkg::pdmc_state_t mode;
   pdmc_pkg::pdmc_bus_t bus_ctl;
   pdmc_pkg::pdmc_clk_en_t clk_en;
   int n_errors, num_checks, per_cnt;
   logic was_settle_q;

   // Short settle counts keep the run small
   pdmc_ctrl #(.WAIT_DIV(WDIV)) pdmc_ctrl_i (.clk_sys(clk_sys), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sleep_req(sleep_req),
      .wdt_timer_mode(wdt_timer_mode), .ext_irq_pin(ext_irq_pin),
      .hw_standby_n_pin(hw_standby_n_pin), .wake(wake), .cpu_run(cpu_run), .osc_run(osc_run),
      .sleep_exc(sleep_exc), .mode(mode), .module_stop_a(module_stop_a),
      .module_stop_b(module_stop_b), .scu_reset(scu_reset), .periph_reset(periph_reset),
      .bus_ctl(bus_ctl), .clk_en(clk_en));
   pdmc_cpu_model pdmc_cpu_model_i (.clk_sys(clk_sys), .reset(reset), .sleep_cmd(sleep_cmd),
      .cpu_run(cpu_run), .sleep_exc(sleep_exc), .sleep_req(sleep_req),
      .exc_count(exc_count));

   // 125 MHz system clock
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   // Peripheral ticks of settle cycles; the enable output lags one clock
   always @(posedge clk_sys) begin
      was_settle_q <= mode === pdmc_pkg::pdmc_settle;
      if (was_settle_q && clk_en.per === 1'b1) begin
         per_cnt <= per_cnt + 1;
      end
   end

   task automatic final_report;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One APB transfer; an idle cycle follows so psel is never set twice at once
   task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {16'h0000, d};
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         n_errors++;
         $display("[FAIL] %0t no bus answer", $time);
         final_report();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 16'h0000);
      check(rd, e);
   endtask
   // Bounded wait for a mode, sampled away from the clock edge
   task automatic wait_mode(input pdmc_pkg::pdmc_state_t m, input int lim);
      int n;
      n = 0;
      @(negedge clk_sys);
      while (mode !== m) begin
         n++;
         if (n > lim) begin
            n_errors++;
            $display("[FAIL] %0t mode wait timed out", $time);
            final_report();
         end
         @(negedge clk_sys);
      end
      @(posedge clk_sys);
   endtask
   task automatic cmd;
      sleep_cmd <= 1'b1;
      @(posedge clk_sys);
      sleep_cmd <= 1'b0;
   endtask
   task automatic go(input pdmc_pkg::pdmc_state_t m);
      cmd();
      wait_mode(m, 10);
   endtask
   task automatic done(input int t);
      $display("test %0d done", t);
   endtask
   // Standby entry, refused timer wake, pin wake and settle tick count
   task automatic stby(input logic [15:0] v, input int n, input logic h);
      wr(`PDMC_OFF_SBY, v);
      per_cnt <= 0;
      go(pdmc_pkg::pdmc_swstby);
      @(negedge clk_sys);
      check(osc_run, 1'b0);
      check(bus_ctl, {~h, h});
      check(scu_reset, 1'b1);
      @(posedge clk_sys);
      wake.tmr <= 1'b1;
      repeat (20) @(posedge clk_sys);
      wake.tmr <= 1'b0;
      check(mode, pdmc_pkg::pdmc_swstby);
      ext_irq_pin <= 1'b1;
      wait_mode(pdmc_pkg::pdmc_settle, 10);
      wait_mode(pdmc_pkg::pdmc_run, 400);
      ext_irq_pin <= 1'b0;
      rd_chk(`PDMC_OFF_SBY, {16'h0000, v & 16'hDF80});
      check(per_cnt, n);
   endtask

   initial begin
      {psel, penable, pwrite, sleep_cmd, wdt_timer_mode, ext_irq_pin} = '0;
      hw_standby_n_pin = 1'b1;
      paddr = '0;
      pwdata = '0;
      wake = '0;
      reset = 1'b1;
      n_errors = 0;
      num_checks = 0;
      per_cnt = 0;
      repeat (8) @(posedge clk_sys);
      reset <= 1'b0;
      wait_mode(pdmc_pkg::pdmc_run, 40000);
      // Reset values, unmapped place, reserved bits, stop bits
      rd_chk(`PDMC_OFF_SBY, 32'h0000_4F00);
      rd_chk(`PDMC_OFF_MSA, 32'h0000_0FFF);
      rd_chk(`PDMC_OFF_MSB, 32'h0000_FFFF);
      rd_chk(12'h020, 32'h0000_0000);
      check(err, 1'b1);
      wr(`PDMC_OFF_SBY, 16'hFFFF);
      rd_chk(`PDMC_OFF_SBY, 32'h0000_DF80);
      wr(`PDMC_OFF_MSA, 16'h0123);
      rd_chk(`PDMC_OFF_MSA, 32'h0000_0123);
      check(module_stop_a, 16'h0123);
      check(module_stop_b, 16'hFFFF);
      done(1);
      // Sleep and wake
      wr(`PDMC_OFF_SBY, 16'h0F00);
      go(pdmc_pkg::pdmc_sleep);
      @(negedge clk_sys);
      check({cpu_run, osc_run}, 2'b01);
      @(posedge clk_sys);
      wake.other <= 1'b1;
      wait_mode(pdmc_pkg::pdmc_run, 10);
      wake.other <= 1'b0;
      done(2);
      // Watchdog mode overrides the standby target
      wdt_timer_mode <= 1'b1;
      wr(`PDMC_OFF_SBY, 16'h8F00);
      go(pdmc_pkg::pdmc_sleep);
      wake.other <= 1'b1;
      wait_mode(pdmc_pkg::pdmc_run, 10);
      wake.other <= 1'b0;
      wdt_timer_mode <= 1'b0;
      done(3);
      // Two settle codes, the second with a slower peripheral clock
      stby(16'h8500, 64 / WDIV, 1'b0);
      wr(`PDMC_OFF_CDIV, 16'h0004);
      rd_chk(`PDMC_OFF_CDIV, 32'h0000_0004);
      // System and bus every clock, peripheral every second clock
      @(negedge clk_sys);
      rd[0] = clk_en.per;
      @(negedge clk_sys);
      check({clk_en.sys, clk_en.bus, clk_en.per ^ rd[0]}, 3'b111);
      @(posedge clk_sys);
      stby(16'hC600, 512 / WDIV, 1'b1);
      done(4);
      // Deep standby
      wr(`PDMC_OFF_DEEP, 16'h0080);
      wr(`PDMC_OFF_SBY, 16'h8500);
      go(pdmc_pkg::pdmc_deep);
      ext_irq_pin <= 1'b1;
      wait_mode(pdmc_pkg::pdmc_settle, 10);
      wait_mode(pdmc_pkg::pdmc_run, 400);
      ext_irq_pin <= 1'b0;
      wr(`PDMC_OFF_DEEP, 16'h0000);
      done(5);
      // All-module clock stop: USB refused, timer wakes
      wr(`PDMC_OFF_SBY, 16'h0500);
      wr(`PDMC_OFF_MSA, 16'hFCFF);
      wr(`PDMC_OFF_MSB, 16'hFFFF);
      go(pdmc_pkg::pdmc_acstop);
      @(negedge clk_sys);
      check(scu_reset, 1'b1);
      check(module_stop_a, 16'hFCFF);
      @(posedge clk_sys);
      wake.usb <= 1'b1;
      repeat (20) @(posedge clk_sys);
      check(mode, pdmc_pkg::pdmc_acstop);
      wake <= 5'h10;
      wait_mode(pdmc_pkg::pdmc_run, 10);
      wake <= 5'h00;
      done(6);
      // Sleep trap with the target kept at 0
      wr(`PDMC_OFF_SBY, 16'h0580);
      cmd();
      repeat (4) @(posedge clk_sys);
      check(exc_count, 8'h01);
      check(mode, pdmc_pkg::pdmc_run);
      rd_chk(`PDMC_OFF_SBY, 32'h0000_0580);
      done(7);
      // Hardware standby pin
      hw_standby_n_pin <= 1'b0;
      wait_mode(pdmc_pkg::pdmc_hwstby, 10);
      @(negedge clk_sys);
      check(periph_reset, 1'b1);
      @(posedge clk_sys);
      hw_standby_n_pin <= 1'b1;
      wait_mode(pdmc_pkg::pdmc_settle, 10);
      wait_mode(pdmc_pkg::pdmc_run, 400);
      done(8);
      final_report();
   end
endmodule
